// file: logic/serial_card_block_and_select.sv
`timescale 1ns/1ps
// What this block does
// - Outside block transfer the transmit interrupt event comes from the transmit-end flag.
// - Normal mode sets the transmit-end flag at 12.5 etu, or 11.0 etu with GSM timing.
// - Block transfer sends no error signal, detects none and never retransmits.
// - Block transfer takes the transmit interrupt event from the data-empty flag.
// - Block transfer sets the transmit-end flag at 11.5 etu, or 11.0 etu with GSM timing.
// - A deselected slave floats its transmit output and holds its serial clock high.
// - In sync mode (control bit 0) a low select input selects the slave and transfer starts at once.
// - Control bit 7 picks GSM timing, which also allows a fixed card clock level.
// - Control bit 6 picks block transfer, clear means normal smart card operation.
module serial_card_block_and_select (
    input  wire logic        I_MCLK,
    input  wire logic        I_RESET,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [4:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_CARD_IO_IN,
    output logic             O_CARD_IO_OUT,
    output logic             O_CARD_IO_OE,
    output logic             O_CARD_CLK,
    input  wire logic        I_SERIAL_CLK,
    input  wire logic        I_SERIAL_RX_IN,
    input  wire logic        I_SELECT_DETECT_N,
    output logic             O_SERIAL_TX_OUT,
    output logic             O_SERIAL_TX_OE,
    output logic             O_INTERNAL_SERIAL_CLK,
    output logic             O_IRQ
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01,
        ST_RETRY = 2'b10
    } tx_state_t;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] pins_s;
    sync2 #(.WIDTH(4), .INIT(4'hf)) u_pins (
        .i_clk   (I_MCLK),
        .i_reset (I_RESET),
        .i_async ({I_CARD_IO_IN, I_SERIAL_CLK, I_SERIAL_RX_IN, I_SELECT_DETECT_N}),
        .o_sync  (pins_s)
    );
    wire card_io_s = pins_s[3];
    wire sck_s     = pins_s[2];
    wire rx_s      = pins_s[1];
    wire sel_n_s   = pins_s[0];

    // ****************************************
    // Wishbone slave
    // ****************************************
    logic [7:0]          ctrl_r;
    logic [15:0]         etu_half_r;
    logic [7:0]          hold_r;
    logic [7:0]          rx_data_r;
    logic                transmit_data_empty_flag_r;
    logic                transmit_end_flag_r;
    logic [sc_sel_pkg::EV_NUM-1:0] irq_stat_r;
    logic [sc_sel_pkg::EV_NUM-1:0] irq_en_r;
    logic [sc_sel_pkg::EV_NUM-1:0] ev;
    logic                ack_r;
    logic [31:0]         dat_r;
    tx_state_t           state_r;

    wire wb_req   = I_WB_CYC & I_WB_STB;
    wire wb_wr    = wb_req & ack_r & I_WB_WE & I_WB_SEL[0];
    wire wr_ctrl  = wb_wr & (I_WB_ADR == sc_sel_pkg::OFS_CTRL);
    wire wr_etu   = wb_wr & (I_WB_ADR == sc_sel_pkg::OFS_ETU);
    wire wr_tx    = wb_wr & (I_WB_ADR == sc_sel_pkg::OFS_TXDATA);
    wire wr_clr   = wb_wr & (I_WB_ADR == sc_sel_pkg::OFS_IRQ_CLR);
    wire wr_en    = wb_wr & (I_WB_ADR == sc_sel_pkg::OFS_IRQ_EN);
    wire wr_etu_hi = wr_etu & I_WB_SEL[1];

    wire gsm      = ctrl_r[sc_sel_pkg::CTRL_GSM];
    wire block_transfer_select = ctrl_r[sc_sel_pkg::CTRL_BLOCK];
    wire sync_md  = ctrl_r[sc_sel_pkg::CTRL_SYNC_MODE];
    wire selected = sync_md & ~sel_n_s;
    wire busy     = state_r != ST_IDLE;

    wire [7:0] status_w = {4'h0, busy, selected, transmit_end_flag_r, transmit_data_empty_flag_r};
    wire [31:0] rd_mux =
        (I_WB_ADR == sc_sel_pkg::OFS_CTRL)     ? {24'h0, ctrl_r} :
        (I_WB_ADR == sc_sel_pkg::OFS_ETU)      ? {16'h0, etu_half_r} :
        (I_WB_ADR == sc_sel_pkg::OFS_TXDATA)   ? {24'h0, hold_r} :
        (I_WB_ADR == sc_sel_pkg::OFS_STATUS)   ? {24'h0, status_w} :
        (I_WB_ADR == sc_sel_pkg::OFS_RXDATA)   ? {24'h0, rx_data_r} :
        (I_WB_ADR == sc_sel_pkg::OFS_IRQ_STAT) ? {29'h0, irq_stat_r} :
        (I_WB_ADR == sc_sel_pkg::OFS_IRQ_EN)   ? {29'h0, irq_en_r} : 32'h0;

    // One wait state; unmapped addresses ack and read zero
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= wb_req & ~ack_r;
            dat_r <= rd_mux;
        end
    end
    assign O_WB_ACK = ack_r;
    assign O_WB_DAT = dat_r;

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            ctrl_r     <= sc_sel_pkg::CTRL_RESET;
            etu_half_r <= sc_sel_pkg::ETU_HALF_RESET;
            irq_en_r   <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= I_WB_DAT[7:0];
            if (wr_etu)
                etu_half_r[7:0] <= I_WB_DAT[7:0];
            if (wr_etu_hi)
                etu_half_r[15:8] <= I_WB_DAT[15:8];
            if (wr_en)
                irq_en_r <= I_WB_DAT[sc_sel_pkg::EV_NUM-1:0];
        end
    end

    // ****************************************
    // Smart card transmitter
    // ****************************************
    logic [15:0] half_cnt_r;
    logic [4:0]  half_idx_r;
    logic [9:0]  frame_r;
    logic        err_seen_r;

    wire in_frame  = state_r == ST_FRAME;
    // Zero rate would stall the frame, so treat it as one
    wire [15:0] half_top = (etu_half_r == 16'h0) ? 16'h0 : etu_half_r - 16'h1;
    wire half_tick = in_frame & (half_cnt_r == half_top);
    wire [4:0] idx_nxt = half_idx_r + 5'h1;
    wire [4:0] tx_end_half = gsm ? sc_sel_pkg::END_GSM_HALF :
                             block_transfer_select ? sc_sel_pkg::END_BLOCK_HALF :
                                                     sc_sel_pkg::END_NORMAL_HALF;
    // Card drives low at the sample point to flag a parity error
    wire err_now   = half_tick & ~block_transfer_select
                     & (idx_nxt == sc_sel_pkg::ERR_SAMPLE_HALF) & ~card_io_s;
    wire frame_end = half_tick & (idx_nxt == tx_end_half);
    wire retry     = frame_end & ~block_transfer_select & (err_seen_r | err_now);
    wire tx_end_set = frame_end & ~retry;
    wire load_sc   = ~sync_md & ~transmit_data_empty_flag_r & (state_r == ST_IDLE);
    wire data_bit  = frame_r[half_idx_r[4:1]];
    wire drive_lo  = in_frame & (half_idx_r < sc_sel_pkg::FRAME_BITS_HALF) & ~data_bit;

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            state_r    <= ST_IDLE;
            half_cnt_r <= 16'h0;
            half_idx_r <= 5'h0;
            frame_r    <= 10'h3ff;
            err_seen_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (load_sc)
                    begin
                        state_r    <= ST_FRAME;
                        frame_r    <= {^hold_r, hold_r, 1'b0};
                        half_cnt_r <= 16'h0;
                        half_idx_r <= 5'h0;
                        err_seen_r <= 1'b0;
                    end
                end
                ST_FRAME:
                begin
                    half_cnt_r <= half_tick ? 16'h0 : half_cnt_r + 16'h1;
                    if (half_tick)
                        half_idx_r <= idx_nxt;
                    if (err_now)
                        err_seen_r <= 1'b1;
                    if (retry)
                        state_r <= ST_RETRY;
                    else if (frame_end)
                        state_r <= ST_IDLE;
                end
                ST_RETRY:
                begin
                    // Wait for the card to release its error pulse
                    if (card_io_s)
                    begin
                        state_r    <= ST_FRAME;
                        half_cnt_r <= 16'h0;
                        half_idx_r <= 5'h0;
                        err_seen_r <= 1'b0;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
    assign O_CARD_IO_OUT = 1'b0;
    assign O_CARD_IO_OE  = drive_lo;

    // ****************************************
    // Card clock output
    // ****************************************
    logic [7:0] clk_div_r;
    logic       card_clk_r;
    wire clk_en    = ctrl_r[sc_sel_pkg::CTRL_CLK_EN];
    wire clk_fixed = gsm & ctrl_r[sc_sel_pkg::CTRL_CLK_LEVEL];
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            clk_div_r  <= 8'h0;
            card_clk_r <= 1'b0;
        end
        else if (clk_div_r == 8'(sc_sel_pkg::CARD_CLK_HALF - 1))
        begin
            clk_div_r  <= 8'h0;
            card_clk_r <= clk_en ? ~card_clk_r : clk_fixed;
        end
        else
            clk_div_r <= clk_div_r + 8'h1;
    end
    assign O_CARD_CLK = card_clk_r;

    // ****************************************
    // Clocked synchronous slave with select
    // ****************************************
    logic       isck_d_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] sync_tx_r;
    logic [7:0] sync_rx_r;
    logic       sel_d_r;

    wire isck      = selected ? sck_s : 1'b1;
    wire sck_rise  = selected & isck & ~isck_d_r;
    wire sck_fall  = selected & ~isck & isck_d_r;
    wire sel_start = selected & ~sel_d_r;
    wire byte_done = sck_rise & (bit_cnt_r == sc_sel_pkg::SYNC_LAST_BIT);
    wire load_sync = sel_start | byte_done;

    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            isck_d_r  <= 1'b1;
            sel_d_r   <= 1'b0;
            bit_cnt_r <= 3'h0;
            sync_tx_r <= 8'hff;
            sync_rx_r <= 8'h0;
        end
        else
        begin
            isck_d_r <= isck;
            sel_d_r  <= selected;
            if (!selected)
                bit_cnt_r <= 3'h0;
            else if (sck_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                sync_rx_r <= {rx_s, sync_rx_r[7:1]};
            end
            if (load_sync)
                sync_tx_r <= hold_r;
            else if (sck_fall && bit_cnt_r != 3'h0)
                sync_tx_r <= {1'b1, sync_tx_r[7:1]};
        end
    end
    assign O_SERIAL_TX_OUT       = sync_tx_r[0];
    assign O_SERIAL_TX_OE        = selected;
    assign O_INTERNAL_SERIAL_CLK = isck;

    // ****************************************
    // Shared holding register and flags
    // ****************************************
    wire load_any = load_sc | load_sync;
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
        begin
            hold_r    <= 8'hff;
            transmit_data_empty_flag_r <= 1'b1;
            transmit_end_flag_r        <= 1'b1;
            rx_data_r <= 8'h0;
        end
        else
        begin
            if (wr_tx)
                hold_r <= I_WB_DAT[7:0];
            transmit_data_empty_flag_r <= wr_tx    ? 1'b0 :
                                          load_any ? 1'b1 : transmit_data_empty_flag_r;
            transmit_end_flag_r <= tx_end_set ? 1'b1 :
                                   wr_tx      ? 1'b0 : transmit_end_flag_r;
            if (byte_done)
                rx_data_r <= {rx_s, sync_rx_r[7:1]};
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // Block mode signals when the holding register empties
    assign ev[sc_sel_pkg::EV_TX_IRQ] = block_transfer_select ? load_sc : tx_end_set;
    assign ev[sc_sel_pkg::EV_ERR] = err_now;
    assign ev[sc_sel_pkg::EV_RX]  = byte_done;
    wire [sc_sel_pkg::EV_NUM-1:0] clr_bits =
        wr_clr ? I_WB_DAT[sc_sel_pkg::EV_NUM-1:0] : '0;
    always_ff @(posedge I_MCLK)
    begin
        if (I_RESET)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~clr_bits) | ev;
    end
    assign O_IRQ = |(irq_stat_r & irq_en_r);

    // ****************************************
    // Assertions
    // ****************************************
    a_irq_from_end: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        ($rose(transmit_end_flag_r) && !$past(block_transfer_select))
        |-> irq_stat_r[sc_sel_pkg::EV_TX_IRQ])
        else $error("transmit interrupt not raised by transmit end");
    a_end_time: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (tx_end_set && !block_transfer_select) |-> (idx_nxt == (gsm ? 5'd22 : 5'd25)))
        else $error("normal transmit end at wrong etu");
    a_block_no_err: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        block_transfer_select |-> (!err_now && !retry))
        else $error("block mode checked for error signal");
    a_irq_from_empty: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (block_transfer_select && load_sc)
        |=> (irq_stat_r[sc_sel_pkg::EV_TX_IRQ] && transmit_data_empty_flag_r))
        else $error("block transmit interrupt not raised by data empty");
    a_block_end_time: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (tx_end_set && block_transfer_select) |-> (idx_nxt == (gsm ? 5'd22 : 5'd23)))
        else $error("block transmit end at wrong etu");
    a_desel_hiz: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        sel_n_s |-> (!O_SERIAL_TX_OE && O_INTERNAL_SERIAL_CLK && bit_cnt_r == 3'h0 ##1 1'b1))
        else $error("deselected slave still active");
    a_sel_start: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (sync_md && $fell(sel_n_s)) |-> O_SERIAL_TX_OE ##1 (sync_tx_r == $past(hold_r)))
        else $error("selected slave did not start");
    a_ctrl_bits: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        wr_ctrl |=> (gsm == $past(I_WB_DAT[7]) && block_transfer_select == $past(I_WB_DAT[6])))
        else $error("control bits misplaced");
    a_etu_step: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (in_frame && half_tick && etu_half_r == 16'h8 && !frame_end)
        |-> ##1 (!half_tick)[*7] ##1 half_tick)
        else $error("half etu step wrong length");
endmodule

// file: logic/sc_sel_pkg.sv
package sc_sel_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_ETU      = 5'h04;
    localparam logic [4:0] OFS_TXDATA   = 5'h08;
    localparam logic [4:0] OFS_STATUS   = 5'h0c;
    localparam logic [4:0] OFS_RXDATA   = 5'h10;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
    localparam logic [4:0] OFS_IRQ_CLR  = 5'h18;
    localparam logic [4:0] OFS_IRQ_EN   = 5'h1c;
    // Control fields
    localparam int CTRL_SYNC_MODE = 0;
    localparam int CTRL_CLK_EN    = 1;
    localparam int CTRL_CLK_LEVEL = 2;
    localparam int CTRL_BLOCK     = 6;
    localparam int CTRL_GSM       = 7;
    // Status fields
    localparam int STAT_TX_EMPTY = 0;
    localparam int STAT_TX_END   = 1;
    localparam int STAT_SELECTED = 2;
    localparam int STAT_BUSY     = 3;
    // Interrupt event bits
    localparam int EV_TX_IRQ = 0;
    localparam int EV_ERR = 1;
    localparam int EV_RX  = 2;
    localparam int EV_NUM = 3;
    // Reset values
    localparam logic [15:0] ETU_HALF_RESET = 16'h00ba;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    // Frame timing in etu, counted as half etu steps
    localparam real END_NORMAL_ETU  = 12.5;
    localparam real END_BLOCK_ETU   = 11.5;
    localparam real END_GSM_ETU     = 11.0;
    localparam real ERR_SAMPLE_ETU  = 11.0;
    localparam real FRAME_BITS_ETU  = 10.0;
    localparam logic [4:0] END_NORMAL_HALF  = 5'(int'(END_NORMAL_ETU * 2.0));
    localparam logic [4:0] END_BLOCK_HALF   = 5'(int'(END_BLOCK_ETU * 2.0));
    localparam logic [4:0] END_GSM_HALF     = 5'(int'(END_GSM_ETU * 2.0));
    localparam logic [4:0] ERR_SAMPLE_HALF  = 5'(int'(ERR_SAMPLE_ETU * 2.0));
    localparam logic [4:0] FRAME_BITS_HALF  = 5'(int'(FRAME_BITS_ETU * 2.0));
    // Card clock half period in device clocks
    localparam int CARD_CLK_HALF = 2;
    localparam logic [2:0] SYNC_LAST_BIT = 3'h7;
endpackage

// file: logic/sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser, one lane per bit
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_lane
            logic meta_r;
            logic sync_r;
            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    meta_r <= INIT[b];
                    sync_r <= INIT[b];
                end
                else
                begin
                    meta_r <= i_async[b];
                    sync_r <= meta_r;
                end
            end
            assign o_sync[b] = sync_r;
        end
    endgenerate
endmodule

// file: test/card_partner.sv
`timescale 1ns/1ps
module card_partner (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_half,
    input  wire logic        i_err_en,
    input  wire logic        i_card_oe,
    input  wire logic        i_tx,
    input  wire logic        i_tx_oe,
    output logic             o_card_io,
    output logic             o_got,
    output logic [7:0]       o_got_byte,
    output logic             o_sclk,
    output logic             o_rx,
    output logic             o_sel_n
);
    logic       pull = 1'b0;
    logic       pulled;
    logic       tx_last = 1'b0;
    logic       tx_line;
    logic [7:0] b;

    // Open-drain card line, pulled up when nobody drives it
    assign o_card_io = ~(i_card_oe | pull);
    // Released slave line never shows the last driven bit
    assign tx_line = i_tx_oe ? i_tx : ~tx_last;

    always @(posedge i_clk)
    begin
        if (i_tx_oe)
            tx_last <= i_tx;
    end

    // ****************************************
    // Card: bytes at bit centres, error pulse on request
    // ****************************************
    initial
    begin
        pulled = 1'b0;
        o_got = 1'b0;
        o_got_byte = 8'h00;
        o_sclk = 1'b1;
        o_rx = 1'b1;
        o_sel_n = 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (o_card_io === 1'b0)
            begin
                repeat (i_half) @(posedge i_clk);
                for (int i = 0; i < 8; i++)
                begin
                    repeat (2 * i_half) @(posedge i_clk);
                    b[i] = o_card_io;
                end
                repeat (4 * i_half) @(posedge i_clk);
                // Only every other frame, so a resend gets through
                pulled = i_err_en & ~pulled;
                pull <= pulled;
                repeat (3 * i_half) @(posedge i_clk);
                pull <= 1'b0;
                o_got_byte <= b;
                o_got <= 1'b1;
                @(posedge i_clk);
                o_got <= 1'b0;
            end
        end
    end

    // ****************************************
    // Master: one byte to this slave or to another one
    // ****************************************
    task automatic sync_xfer(input logic me, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_sel_n <= ~me;
        repeat (16) @(posedge i_clk);
        for (int i = 0; i < 8; i++)
        begin
            o_sclk <= 1'b0;
            o_rx <= d[i];
            repeat (8) @(posedge i_clk);
            o_sclk <= 1'b1;
            q[i] = tx_line;
            repeat (8) @(posedge i_clk);
        end
        repeat (8) @(posedge i_clk);
        o_sel_n <= 1'b1;
        repeat (16) @(posedge i_clk);
    endtask
endmodule

// file: test/serial_card_block_and_select_test.sv
`timescale 1ns/1ps
module serial_card_block_and_select_test;
    localparam logic [4:0] A_CTRL = sc_sel_pkg::OFS_CTRL;
    localparam logic [4:0] A_TX   = sc_sel_pkg::OFS_TXDATA;
    localparam logic [4:0] A_IS   = sc_sel_pkg::OFS_IRQ_STAT;
    localparam logic [4:0] A_IC   = sc_sel_pkg::OFS_IRQ_CLR;
    localparam logic [4:0] A_IE   = sc_sel_pkg::OFS_IRQ_EN;
    logic        clk, rst, cyc, stb, we, ack, card_oe, card_out, card_clk, card_io;
    logic        sclk, rx, sel_n, tx, tx_oe, isclk, irq, got;
    logic        irq_d = 1'b0;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat, last_rd;
    logic [7:0]  got_byte, b, r, q;
    logic [15:0] half   = 16'h0008;
    logic        err_en = 1'b0;
    logic        watch  = 1'b0;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0]  card_q[$];
    logic [7:0]  ctl[4] = '{8'h00, 8'h80, 8'h40, 8'hc0};
    int          th[4]  = '{25, 22, 23, 22};
    int          bad_count = 0;
    int          checked   = 0;
    integer      seed      = 32'h183a8b17;
    time         t_irq     = 0;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    serial_card_block_and_select serial_card_block_and_select_inst (
        .I_MCLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_SEL(sel), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_CARD_IO_IN(card_io), .O_CARD_IO_OUT(card_out), .O_CARD_IO_OE(card_oe),
        .O_CARD_CLK(card_clk), .I_SERIAL_CLK(sclk), .I_SERIAL_RX_IN(rx),
        .I_SELECT_DETECT_N(sel_n), .O_SERIAL_TX_OUT(tx), .O_SERIAL_TX_OE(tx_oe),
        .O_INTERNAL_SERIAL_CLK(isclk), .O_IRQ(irq));

    card_partner card_partner_inst (
        .i_clk(clk), .i_half(half), .i_err_en(err_en), .i_card_oe(card_oe), .i_tx(tx),
        .i_tx_oe(tx_oe), .o_card_io(card_io), .o_got(got), .o_got_byte(got_byte),
        .o_sclk(sclk), .o_rx(rx), .o_sel_n(sel_n));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic cmp_win(input string what, input int s, input int lo, input int hi);
        checked++;
        if (s < lo || s > hi)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, s);
        end
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Master never assumes a latency; read data noted for the watcher
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] m);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        exp_q.push_back(d);
        msk_q.push_back(w ? 32'h0 : m);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        last_rd = rdat;
        if (n >= 20) cmp("bus ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic run_frame(input logic [7:0] c, input logic e, input int th_i);
        time t0;
        int  n;
        int  d;
        b = 8'($random(seed));
        d = th_i * int'(half);
        err_en <= e;
        wb(1'b1, A_CTRL, {24'h0, c}, 0);
        wb(1'b1, A_IC, 32'h7, 0);
        wb(1'b1, A_IE, 32'h1, 0);
        card_q.push_back(b);
        if (e && !c[6]) card_q.push_back(b);
        t_irq = 0;
        wb(1'b1, A_TX, {24'h0, b}, 0);
        n = 0;
        while (card_oe !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        t0 = $time;
        n = 0;
        do
        begin
            wb(1'b0, sc_sel_pkg::OFS_STATUS, 0, 0);
            n++;
        end
        while (last_rd[sc_sel_pkg::STAT_TX_END] !== 1'b1 && n < 400);
        if (!e)
        begin
            cmp_win("end flag delay", int'(($time - t0) / 10), d - 2, d + 6);
            if (c[6]) cmp_win("irq delay", int'(t_irq / 10) - int'(t0 / 10), 0, 5);
            else cmp_win("irq delay", int'(t_irq / 10) - int'(t0 / 10), d - 2, d + 8);
        end
        wb(1'b0, A_IS, {30'h0, e & ~c[6], 1'b0}, 32'h2);
        repeat (4 * half) @(posedge clk);
        $display("Test card frame ctrl %h error %0d done", c, e);
    endtask

    // ****************************************
    // Watchers and main sequence
    // ****************************************
    always @(posedge clk)
    begin
        irq_d <= irq;
        if (irq === 1'b1 && irq_d !== 1'b1) t_irq = $time;
        if (ack === 1'b1 && exp_q.size() > 0)
        begin
            if (msk_q[0] != 0) cmp("register read", exp_q[0] & msk_q[0], rdat & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (got === 1'b1)
        begin
            if (card_q.size() == 0) cmp("card byte", 32'h100, {24'h0, got_byte});
            else cmp("card byte", {24'h0, card_q.pop_front()}, {24'h0, got_byte});
        end
        if (watch) cmp("deselected pins", 32'h1, {30'h0, tx_oe, isclk});
    end

    initial
    begin
        #200_000;
        cmp("watchdog", 32'h0, 32'h1);
        stop_test();
    end

    initial
    begin
        {rst, cyc, stb, we, sel, adr, wdat} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, A_CTRL, 32'h0, 32'hffffffff);
        wb(1'b0, sc_sel_pkg::OFS_ETU, 32'h00ba, 32'hffffffff);
        wb(1'b0, sc_sel_pkg::OFS_STATUS, 32'h3, 32'hf);
        wb(1'b0, A_IS, 32'h0, 32'hffffffff);
        wb(1'b0, 5'h1e, 32'h0, 32'hffffffff);
        wb(1'b1, sc_sel_pkg::OFS_ETU, {16'h0, half}, 0);
        wb(1'b0, sc_sel_pkg::OFS_ETU, {16'h0, half}, 32'hffff);
        wb(1'b1, A_CTRL, 32'h84, 0);
        repeat (3) @(posedge clk);
        cmp("card clock", 32'h1, {31'h0, card_clk});
        wb(1'b1, A_CTRL, 32'h04, 0);
        repeat (3) @(posedge clk);
        cmp("card clock", 32'h0, {31'h0, card_clk});
        cmp("card drive level", 32'h0, {31'h0, card_out});
        $display("Test reset and clock done");
        for (int i = 0; i < 4; i++) run_frame(ctl[i], 1'b0, th[i]);
        run_frame(8'h00, 1'b1, 25);
        run_frame(8'h40, 1'b1, 23);
        wb(1'b1, A_CTRL, 32'h01, 0);
        wb(1'b1, A_IC, 32'h7, 0);
        wb(1'b1, A_IE, 32'h4, 0);
        for (int k = 0; k < 2; k++)
        begin
            b = 8'($random(seed));
            r = 8'($random(seed));
            wb(1'b1, A_TX, {24'h0, b}, 0);
            card_partner_inst.sync_xfer(1'b1, r, q);
            cmp("sync byte", {24'h0, b}, {24'h0, q});
            wb(1'b0, sc_sel_pkg::OFS_RXDATA, {24'h0, r}, 32'hff);
        end
        wb(1'b0, A_IS, 32'h4, 32'h4);
        cmp("interrupt", 32'h1, {31'h0, irq});
        wb(1'b1, A_IE, 32'h0, 0);
        repeat (2) @(posedge clk);
        cmp("interrupt", 32'h0, {31'h0, irq});
        wb(1'b1, A_IE, 32'h4, 0);
        wb(1'b1, A_IC, 32'h4, 0);
        repeat (2) @(posedge clk);
        cmp("interrupt", 32'h0, {31'h0, irq});
        repeat (4) @(posedge clk);
        watch <= 1'b1;
        card_partner_inst.sync_xfer(1'b0, 8'h5a, q);
        watch <= 1'b0;
        $display("Test select done");
        stop_test();
    end
endmodule
